// ### hdl/psau_pkg.sv
package psau_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_FREQ_KHZ = 125000;
  localparam int FRC_FREQ_KHZ = 7370;
  localparam int ROW_WRITE_FRC_CYCLES = 11064;
  // Nominal oscillator rate, so the figure is truncated, not padded
  localparam longint ROW_WRITE_CLK_CYCLES =
    (longint'(ROW_WRITE_FRC_CYCLES) * longint'(CLK_FREQ_KHZ)) / longint'(FRC_FREQ_KHZ);
  localparam int TIMER_W = 18;

  // ---------------------------------------------------------------
  // Register map (16-bit registers on a 4-bit index)
  // ---------------------------------------------------------------
  localparam logic [3:0] TABLE_PAGE_OFS = 4'h0;
  localparam logic [3:0] VISIBILITY_PAGE_OFS = 4'h1;
  localparam logic [3:0] CORE_CONTROL_OFS = 4'h2;
  localparam logic [3:0] FLASH_CONTROL_OFS = 4'h3;
  localparam logic [3:0] FLASH_UNLOCK_KEY_OFS = 4'h4;
  localparam logic [15:0] REG_RESET = 16'h0000;

  localparam int WINDOW_EN_BIT = 2;
  localparam int WR_BIT = 15;
  localparam int WREN_BIT = 14;
  localparam int WRERR_BIT = 13;
  localparam int ERASE_BIT = 6;

  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  localparam logic [3:0] OP_ROW_PROGRAM = 4'h1;
  localparam logic [3:0] OP_WORD_PROGRAM = 4'h3;
  localparam logic [3:0] OP_PAGE_ERASE = 4'h2;

  // ---------------------------------------------------------------
  // Array geometry
  // ---------------------------------------------------------------
  localparam int USER_WORDS = 1024;
  localparam int ROW_WORDS = 64;
  localparam int PAGE_WORDS = 512;
  localparam int CFG_WORDS = 8;
  localparam logic [23:0] ERASED_WORD = 24'hffffff;

  typedef enum logic [2:0] {
    REQ_TABLE_READ_LOW = 3'b000,
    REQ_TABLE_READ_HIGH = 3'b001,
    REQ_TABLE_WRITE_LOW = 3'b010,
    REQ_TABLE_WRITE_HIGH = 3'b011,
    REQ_DATA_READ = 3'b100
  } psau_kind_t;

  typedef enum logic [1:0] {
    CLASS_TRANSFER = 2'b00,
    CLASS_DOUBLE_TRANSFER = 2'b01,
    CLASS_OTHER = 2'b10
  } psau_class_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_TABLE_WRITE = 2'b01,
    ST_WINDOW_WAIT = 2'b10,
    ST_FLASH_BUSY = 2'b11
  } psau_fsm_t;

  typedef struct packed {
    psau_kind_t kind;
    logic byte_mode;
    logic [15:0] effective_address;
    logic [15:0] wdata;
    psau_class_t iclass;
    logic in_repeat;
    logic repeat_first;
    logic repeat_last;
    logic irq_exit;
    logic irq_reenter;
  } psau_core_req_t;

  typedef struct packed {
    logic valid;
    logic window_hit;
    logic [15:0] data;
  } psau_core_resp_t;

endpackage : psau_pkg

// ### hdl/psau_program_space_access_unit.sv
// The plain strobed port and the address map were decided locally.
module psau_program_space_access_unit #(
  parameter int ROW_WRITE_CYCLES = int'(psau_pkg::ROW_WRITE_CLK_CYCLES)
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  input wire logic core_req_valid,
  input wire psau_pkg::psau_core_req_t core_req,
  output psau_pkg::psau_core_resp_t core_resp,
  output logic core_stall,
  output logic flash_busy
);
  import psau_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    psau_fsm_t fsm;
    logic [7:0] table_page;
    logic [7:0] visibility_page;
    logic window_en;
    logic wr;
    logic wren;
    logic wrerr;
    logic erase;
    logic [3:0] op;
    logic [1:0] key_stage;
    logic [TIMER_W-1:0] timer;
    logic [1:0] extra_cnt;
    logic [23:0] commit_addr;
    logic [15:0] bus_rdata;
    psau_core_resp_t resp;
    psau_core_resp_t held;
    logic [ROW_WORDS-1:0][23:0] hold_buf;
    logic [USER_WORDS-1:0][23:0] user_mem;
    logic [CFG_WORDS-1:0][23:0] cfg_mem;
  } psau_state_t;

  localparam logic [TIMER_W-1:0] ROW_TIMER = TIMER_W'(ROW_WRITE_CYCLES);

  psau_state_t state_reg;
  psau_state_t state_next;

  // ---------------------------------------------------------------
  // Decoding helpers
  // ---------------------------------------------------------------
  // user or config
  function automatic logic [23:0] fetch_word(input psau_state_t s, input logic [23:0] paddr);
    if (paddr[23]) begin
      return s.cfg_mem[paddr[3:1]];
    end
    return s.user_mem[paddr[10:1]];
  endfunction : fetch_word

  function automatic logic [15:0] table_read_data(input logic [23:0] w, input logic high,
                                                  input logic byte_mode, input logic sel);
    if (!high) begin
      if (!byte_mode) begin
        return w[15:0];
      end
      return {8'h00, (sel ? w[15:8] : w[7:0])};
    end
    if (!byte_mode) begin
      return {8'h00, w[23:16]};
    end
    return {8'h00, (sel ? 8'h00 : w[23:16])};
  endfunction : table_read_data

  function automatic logic [1:0] window_extra(input psau_core_req_t r);
    if (r.in_repeat) begin
      if (r.repeat_first || r.repeat_last || r.irq_exit || r.irq_reenter) begin
        return 2'd2;
      end
      return 2'd0;
    end
    if (r.iclass == CLASS_TRANSFER || r.iclass == CLASS_DOUBLE_TRANSFER) begin
      return 2'd1;
    end
    return 2'd2;
  endfunction : window_extra

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  logic [23:0] table_addr;
  logic [23:0] window_addr;
  logic [5:0] buf_idx;
  logic start_flash;
  logic [15:0] ctl_view;
  logic [23:0] window_word;

  always_comb begin
    state_next = state_reg;
    state_next.resp.valid = 1'b0;
    start_flash = 1'b0;
    table_addr = {state_reg.table_page, core_req.effective_address};
    window_addr = {1'b0, state_reg.visibility_page, core_req.effective_address[14:0]};
    // Fetched into a net of its own, a call result cannot be part-selected
    window_word = fetch_word(state_reg, window_addr);
    buf_idx = core_req.effective_address[6:1];
    ctl_view = 16'h0000;
    ctl_view[WR_BIT] = state_reg.wr;
    ctl_view[WREN_BIT] = state_reg.wren;
    ctl_view[WRERR_BIT] = state_reg.wrerr;
    ctl_view[ERASE_BIT] = state_reg.erase;
    ctl_view[3:0] = state_reg.op;

    // Read data stands for exactly one cycle
    state_next.bus_rdata = REG_RESET;
    if (reg_read) begin
      case (reg_addr)
        TABLE_PAGE_OFS: state_next.bus_rdata = {8'h00, state_reg.table_page};
        VISIBILITY_PAGE_OFS: state_next.bus_rdata = {8'h00, state_reg.visibility_page};
        CORE_CONTROL_OFS: state_next.bus_rdata = 16'(state_reg.window_en) << WINDOW_EN_BIT;
        FLASH_CONTROL_OFS: state_next.bus_rdata = ctl_view;
        default: state_next.bus_rdata = REG_RESET;
      endcase
    end

    if (reg_write) begin
      // Any write other than the second key breaks the unlock sequence
      state_next.key_stage = 2'd0;
      case (reg_addr)
        TABLE_PAGE_OFS: state_next.table_page = reg_wdata[7:0];
        VISIBILITY_PAGE_OFS: state_next.visibility_page = reg_wdata[7:0];
        CORE_CONTROL_OFS: state_next.window_en = reg_wdata[WINDOW_EN_BIT];
        FLASH_UNLOCK_KEY_OFS: begin
          if (reg_wdata[7:0] == KEY_FIRST) begin
            state_next.key_stage = 2'd1;
          end else if (reg_wdata[7:0] == KEY_SECOND && state_reg.key_stage == 2'd1) begin
            state_next.key_stage = 2'd2;
          end
        end
        FLASH_CONTROL_OFS: begin
          state_next.wren = reg_wdata[WREN_BIT];
          state_next.erase = reg_wdata[ERASE_BIT];
          state_next.op = reg_wdata[3:0];
          state_next.wrerr = reg_wdata[WRERR_BIT];
          if (!state_reg.wr && !reg_wdata[WR_BIT]) begin
            state_next.wr = 1'b0;
          end
          if (reg_wdata[WR_BIT] && !state_reg.wr) begin
            if (state_reg.key_stage == 2'd2 && reg_wdata[WREN_BIT] && state_reg.fsm == ST_IDLE) begin
              start_flash = 1'b1;
            end else begin
              // Hardware-set error wins over the software clear above
              state_next.wrerr = 1'b1;
            end
          end
        end
        default: state_next.key_stage = 2'd0;
      endcase
    end

    case (state_reg.fsm)
      ST_IDLE: begin
        if (start_flash) begin
          state_next.wr = 1'b1;
          state_next.fsm = ST_FLASH_BUSY;
          state_next.timer = ROW_TIMER;
        end else if (core_req_valid) begin
          case (core_req.kind)
            REQ_TABLE_READ_LOW, REQ_TABLE_READ_HIGH: begin
              state_next.resp.valid = 1'b1;
              state_next.resp.window_hit = 1'b0;
              state_next.resp.data = table_read_data(fetch_word(state_reg, table_addr),
                                                     core_req.kind == REQ_TABLE_READ_HIGH,
                                                     core_req.byte_mode,
                                                     core_req.effective_address[0]);
            end
            REQ_TABLE_WRITE_LOW: begin
              if (!core_req.byte_mode) begin
                state_next.hold_buf[buf_idx][15:0] = core_req.wdata;
              end else if (core_req.effective_address[0]) begin
                state_next.hold_buf[buf_idx][15:8] = core_req.wdata[7:0];
              end else begin
                state_next.hold_buf[buf_idx][7:0] = core_req.wdata[7:0];
              end
              state_next.commit_addr = table_addr;
              state_next.fsm = ST_TABLE_WRITE;
            end
            REQ_TABLE_WRITE_HIGH: begin
              if (!core_req.byte_mode || !core_req.effective_address[0]) begin
                state_next.hold_buf[buf_idx][23:16] = core_req.wdata[7:0];
              end
              state_next.commit_addr = table_addr;
              state_next.fsm = ST_TABLE_WRITE;
            end
            REQ_DATA_READ: begin
              state_next.held.valid = 1'b1;
              state_next.held.window_hit = core_req.effective_address[15] && state_reg.window_en;
              state_next.held.data = 16'h0000;
              if (state_next.held.window_hit) begin
                state_next.held.data = window_word[15:0];
              end
              state_next.extra_cnt = window_extra(core_req);
              if (!state_next.held.window_hit || state_next.extra_cnt == 2'd0) begin
                state_next.resp = state_next.held;
              end else begin
                state_next.fsm = ST_WINDOW_WAIT;
              end
            end
            default: state_next.fsm = ST_IDLE;
          endcase
        end
      end
      ST_TABLE_WRITE: begin
        state_next.resp.valid = 1'b1;
        state_next.resp.window_hit = 1'b0;
        state_next.resp.data = 16'h0000;
        state_next.fsm = ST_IDLE;
      end
      ST_WINDOW_WAIT: begin
        state_next.extra_cnt = state_reg.extra_cnt - 2'd1;
        if (state_reg.extra_cnt == 2'd1) begin
          state_next.resp = state_reg.held;
          state_next.fsm = ST_IDLE;
        end
      end
      ST_FLASH_BUSY: begin
        state_next.timer = state_reg.timer - TIMER_W'(1);
        if (state_reg.timer == TIMER_W'(1)) begin
          state_next.wr = 1'b0;
          state_next.fsm = ST_IDLE;
          // Configuration space is never committed from this path
          if (!state_reg.commit_addr[23]) begin
            if (!state_reg.erase && state_reg.op == OP_ROW_PROGRAM) begin
              for (int i = 0; i < ROW_WORDS; i++) begin
                state_next.user_mem[{state_reg.commit_addr[10:7], 6'(i)}] = state_reg.hold_buf[i];
              end
            end else if (!state_reg.erase && state_reg.op == OP_WORD_PROGRAM) begin
              state_next.user_mem[state_reg.commit_addr[10:1]] =
                state_reg.hold_buf[state_reg.commit_addr[6:1]];
            end else if (state_reg.erase && state_reg.op == OP_PAGE_ERASE) begin
              for (int i = 0; i < PAGE_WORDS; i++) begin
                state_next.user_mem[{state_reg.commit_addr[10], 9'(i)}] = ERASED_WORD;
              end
            end
          end
        end
      end
      default: state_next.fsm = ST_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign reg_rdata = state_reg.bus_rdata;
  assign core_resp = state_reg.resp;
  assign core_stall = (state_reg.fsm != ST_IDLE);
  assign flash_busy = (state_reg.fsm == ST_FLASH_BUSY);

endmodule : psau_program_space_access_unit

// ### sim/psau_program_space_access_unit_monitor.sv
module psau_program_space_access_unit_monitor #(
  parameter int ROW_WRITE_CYCLES = 20
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_rdata,
  input wire logic core_req_valid,
  input wire psau_pkg::psau_core_req_t core_req,
  input wire psau_pkg::psau_core_resp_t core_resp,
  input wire logic core_stall,
  input wire logic flash_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  import psau_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic win_en_reg;
  int busy_cnt_reg;
  logic take;
  logic win;
  assign take = core_req_valid && !core_stall;
  assign win = take && core_req.kind == REQ_DATA_READ && core_req.effective_address[15] && win_en_reg;
  // Shadow of the enable so window hits can be predicted from the ports
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      win_en_reg <= 1'b0;
      busy_cnt_reg <= 0;
    end else begin
      if (reg_write && reg_addr == CORE_CONTROL_OFS) begin
        win_en_reg <= reg_wdata[WINDOW_EN_BIT];
      end
      busy_cnt_reg <= flash_busy ? busy_cnt_reg + 1 : 0;
    end
  end
  property p_high_word;
    take && core_req.kind == REQ_TABLE_READ_HIGH && !core_req.byte_mode |=>
      core_resp.valid && core_resp.data[15:8] == 8'h00;
  endproperty
  a_high_word: assert property (p_high_word) else $error("high word read upper byte not zero");
  property p_phantom;
    take && core_req.kind == REQ_TABLE_READ_HIGH && core_req.byte_mode && core_req.effective_address[0] |=>
      core_resp.valid && core_resp.data == 16'h0000;
  endproperty
  a_phantom: assert property (p_phantom) else $error("phantom byte read not zero");
  property p_write_two;
    take && core_req.kind inside {REQ_TABLE_WRITE_LOW, REQ_TABLE_WRITE_HIGH} |=>
      core_stall ##1 (core_resp.valid && !core_stall);
  endproperty
  a_write_two: assert property (p_write_two) else $error("table write not two cycles");
  property p_no_window;
    take && core_req.kind == REQ_DATA_READ && !(core_req.effective_address[15] && win_en_reg) |=>
      core_resp.valid && !core_resp.window_hit;
  endproperty
  a_no_window: assert property (p_no_window) else $error("window hit without address bit or enable");
  property p_window_one;
    win && !core_req.in_repeat && core_req.iclass != CLASS_OTHER |=>
      core_stall ##1 (core_resp.valid && core_resp.window_hit);
  endproperty
  a_window_one: assert property (p_window_one) else $error("transfer window access not one extra cycle");
  property p_repeat_mid;
    win && core_req.in_repeat && !(core_req.repeat_first || core_req.repeat_last || core_req.irq_exit ||
      core_req.irq_reenter) |=> core_resp.valid && core_resp.window_hit && !core_stall;
  endproperty
  a_repeat_mid: assert property (p_repeat_mid) else $error("middle repeat iteration not single cycle");
  property p_table_no_window;
    take && core_req.kind inside {REQ_TABLE_READ_LOW, REQ_TABLE_READ_HIGH} |=> core_resp.valid && !core_resp.window_hit;
  endproperty
  a_table_no_window: assert property (p_table_no_window) else $error("window used by table read");
  property p_stall_busy;
    flash_busy |-> core_stall && !core_resp.valid;
  endproperty
  a_stall_busy: assert property (p_stall_busy) else $error("core not stalled during flash operation");
  property p_row_time;
    $fell(flash_busy) |-> busy_cnt_reg == ROW_WRITE_CYCLES;
  endproperty
  a_row_time: assert property (p_row_time) else $error("flash operation length wrong");
endmodule : psau_program_space_access_unit_monitor

bind psau_program_space_access_unit psau_program_space_access_unit_monitor #(.ROW_WRITE_CYCLES(ROW_WRITE_CYCLES)) u_mon (
  .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
  .reg_read(reg_read), .reg_rdata(reg_rdata), .core_req_valid(core_req_valid), .core_req(core_req),
  .core_resp(core_resp), .core_stall(core_stall), .flash_busy(flash_busy));

// ### sim/psau_core_model.sv
module psau_core_model (
  input wire logic clock,
  input wire logic core_stall,
  input wire psau_pkg::psau_core_resp_t core_resp,
  output logic core_req_valid,
  output psau_pkg::psau_core_req_t core_req
);
  timeunit 1ns;
  timeprecision 1ps;
  import psau_pkg::*;
  initial begin
    core_req_valid = 1'b0;
    core_req = '0;
  end
  // Whole requests, one at a time
  task automatic xfer(input logic [42:0] req, output logic [15:0] data, output logic hit, output int lat);
    // A request raised while stalled would be dropped silently
    while (core_stall !== 1'b0) begin
      @(negedge clock);
    end
    @(posedge clock);
    core_req_valid <= 1'b1;
    core_req <= req;
    @(posedge clock);
    core_req_valid <= 1'b0;
    // Released lines are inverted so a stale request is never mistaken for a live one
    core_req <= ~req;
    lat = 0;
    do begin
      @(negedge clock);
      lat++;
    end while (core_resp.valid !== 1'b1 && lat < 9);
    data = core_resp.data;
    hit = core_resp.window_hit;
  endtask : xfer
endmodule : psau_core_model

// ### sim/psau_program_space_access_unit_tb.sv
module psau_program_space_access_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import psau_pkg::*;
  localparam int RWC = 20;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [15:0] reg_rdata;
  logic core_req_valid;
  psau_core_req_t core_req;
  psau_core_resp_t core_resp;
  logic core_stall;
  logic flash_busy;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [15:0] d;
  logic h;
  int lat;
  psau_class_t cl [8] = '{CLASS_TRANSFER, CLASS_DOUBLE_TRANSFER, CLASS_OTHER, CLASS_OTHER, CLASS_OTHER,
    CLASS_OTHER, CLASS_OTHER, CLASS_OTHER};
  logic [4:0] rp [8] = '{5'h00, 5'h00, 5'h00, 5'h10, 5'h18, 5'h14, 5'h12, 5'h11};
  int el [8] = '{2, 2, 3, 1, 3, 3, 3, 3};

  psau_program_space_access_unit #(.ROW_WRITE_CYCLES(RWC)) DUT (
    .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .core_req_valid(core_req_valid), .core_req(core_req),
    .core_resp(core_resp), .core_stall(core_stall), .flash_busy(flash_busy));
  psau_core_model u_core (.clock(clock), .core_stall(core_stall), .core_resp(core_resp),
    .core_req_valid(core_req_valid), .core_req(core_req));

  initial begin
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    chk("register", exp, reg_rdata);
  endtask : rd
  task automatic acc(input psau_kind_t k, input logic bm, input logic [15:0] ea, input logic [15:0] wd,
                     input psau_class_t c, input logic [4:0] r);
    u_core.xfer({k, bm, ea, wd, c, r}, d, h, lat);
  endtask : acc
  task automatic trd(input psau_kind_t k, input logic bm, input logic [15:0] ea, input logic [15:0] exp);
    acc(k, bm, ea, 16'h0000, CLASS_OTHER, 5'h00);
    chk("table read", exp, d);
  endtask : trd
  task automatic flash_op(input logic [15:0] ctl);
    int n;
    n = 0;
    wr(FLASH_UNLOCK_KEY_OFS, {8'h00, KEY_FIRST});
    wr(FLASH_UNLOCK_KEY_OFS, {8'h00, KEY_SECOND});
    wr(FLASH_CONTROL_OFS, ctl);
    @(negedge clock);
    chk("stall and busy", 16'h0001, {15'h0000, core_stall & flash_busy});
    while (flash_busy === 1'b1 && n < 100) begin
      @(negedge clock);
      n++;
    end
    chk("busy cycles", 16'(RWC), 16'(n));
    rd(FLASH_CONTROL_OFS, ctl & 16'h7fff);
  endtask : flash_op

  initial begin
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd(4'(i), 16'h0000);
    end
    // Start without the unlock keys must be refused
    wr(FLASH_CONTROL_OFS, 16'hc001);
    rd(FLASH_CONTROL_OFS, 16'h6001);
    acc(REQ_TABLE_WRITE_LOW, 1'b0, 16'h0010, 16'h1234, CLASS_OTHER, 5'h00);
    chk("write cycles", 16'h0002, 16'(lat));
    acc(REQ_TABLE_WRITE_HIGH, 1'b0, 16'h0010, 16'h00ff, CLASS_OTHER, 5'h00);
    trd(REQ_TABLE_READ_LOW, 1'b0, 16'h0010, 16'h0000);
    flash_op(16'hc001);
    trd(REQ_TABLE_READ_LOW, 1'b0, 16'h0010, 16'h1234);
    trd(REQ_TABLE_READ_LOW, 1'b1, 16'h0010, 16'h0034);
    trd(REQ_TABLE_READ_LOW, 1'b1, 16'h0011, 16'h0012);
    trd(REQ_TABLE_READ_HIGH, 1'b0, 16'h0010, 16'h00ff);
    trd(REQ_TABLE_READ_HIGH, 1'b1, 16'h0010, 16'h00ff);
    trd(REQ_TABLE_READ_HIGH, 1'b1, 16'h0011, 16'h0000);
    trd(REQ_TABLE_READ_LOW, 1'b0, 16'h0012, 16'h0000);
    wr(TABLE_PAGE_OFS, 16'h0080);
    trd(REQ_TABLE_READ_LOW, 1'b0, 16'h0010, 16'h0000);
    wr(TABLE_PAGE_OFS, 16'h0000);
    wr(CORE_CONTROL_OFS, 16'h0004);
    wr(VISIBILITY_PAGE_OFS, 16'h0001);
    for (int i = 0; i < 8; i++) begin
      acc(REQ_DATA_READ, 1'b0, 16'h8010, 16'h0000, cl[i], rp[i]);
      chk("window data", 16'h1234, d);
      chk("window hit", 16'h0001, {15'h0000, h});
      chk("window cycles", 16'(el[i]), 16'(lat));
    end
    trd(REQ_TABLE_READ_LOW, 1'b0, 16'h8010, 16'h1234);
    chk("table hit", 16'h0000, {15'h0000, h});
    wr(CORE_CONTROL_OFS, 16'h0000);
    acc(REQ_DATA_READ, 1'b0, 16'h8010, 16'h0000, CLASS_TRANSFER, 5'h00);
    chk("disabled hit", 16'h0000, {15'h0000, h});
    chk("disabled data", 16'h0000, d);
    acc(REQ_TABLE_WRITE_LOW, 1'b0, 16'h0010, 16'h5678, CLASS_OTHER, 5'h00);
    flash_op(16'hc003);
    trd(REQ_TABLE_READ_LOW, 1'b0, 16'h0010, 16'h5678);
    flash_op(16'hc042);
    trd(REQ_TABLE_READ_LOW, 1'b0, 16'h0010, 16'hffff);
    trd(REQ_TABLE_READ_HIGH, 1'b0, 16'h0010, 16'h00ff);
    give_verdict();
  end
endmodule : psau_program_space_access_unit_tb
